// File: logic/eight_bit_timer_counter.sv
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// R1 - 8-bit rw count; wrap sets overflow flag
// R2 - source select clear: count each instruction cycle
// R3 - count write holds counting two instruction cycles
// R4 - source select set: count external pin edges
// R5 - edge select: clear rising, set falling
// R6 - one hidden prescaler, timer or watchdog only
// R7 - assign bit and ratio in option bits 3:0
// R8 - count write clears prescaler when timer-assigned
// R9 - watchdog clear clears prescaler when watchdog-assigned
// R10 - flag bit 2, enable bit 5 masks only
// R11 - software clears flag before re-enabling interrupt
// R12 - timer halts in sleep, cannot wake
// R13 - prescaler output sampled on phases Q2, Q4
// R14 - external input high and low two oscillator periods
// R15 - watchdog keeps own scaling when prescaler unassigned
// R16 - assign set means watchdog; codes divide 2..256
// R17 - option low four bits reset to one
module eight_bit_timer_counter
    import timer_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        external_count_input,
    input  wire logic        sleep_mode,
    input  wire logic        watchdog_clear_instr,
    input  wire logic        wdt_base_tick,
    output logic             wdt_scaled_tick,
    output logic             irq
);
    phase_t      phase_r;
    phase_t      phase_nxt;
    logic        ack_r;
    logic [31:0] dat_r;
    logic [7:0]  timer_count_reg_r;
    logic [7:0]  timer_count_reg_nxt;
    logic [7:0]  timer_option_control_r;
    logic        overflow_flag_r;
    logic        overflow_flag_nxt;
    logic        overflow_irq_enable_r;
    logic        evt_status_r;
    logic        evt_status_nxt;
    logic        evt_mask_r;
    logic [1:0]  inhibit_r;
    logic [1:0]  inhibit_nxt;
    logic        ext_s1_r;
    logic        ext_s2_r;
    logic        ext_s3_r;
    logic        ext_lvl_r;
    logic        src_prev_r;
    logic        smp_r;
    logic        irq_r;
    logic        wdt_tick_r;

    // bus request decode
    wire         take       = wb_cyc_i && wb_stb_i && !ack_r;
    wire         wr_lane0   = take && wb_we_i && wb_sel_i[0];
    wire         wr_cnt     = wr_lane0 && (wb_adr_i == ADR_COUNT);
    wire         wr_opt     = wr_lane0 && (wb_adr_i == ADR_OPTION);
    wire         wr_intc    = wr_lane0 && (wb_adr_i == ADR_INTCTL);
    wire         wr_mask    = wr_lane0 && (wb_adr_i == ADR_EVT_MASK);
    wire         rd_status  = take && !wb_we_i && (wb_adr_i == ADR_EVT_STATUS);

    // option fields
    wire                   src_sel    = timer_option_control_r[OPT_SRC_SEL_BIT];
    wire                   edge_sel   = timer_option_control_r[OPT_EDGE_BIT];
    wire                   to_wdt     = timer_option_control_r[OPT_ASSIGN_BIT];  // R16
    wire [OPT_RATIO_W-1:0] ratio      =
        timer_option_control_r[OPT_RATIO_LSB +: OPT_RATIO_W];                  // R7

    // phase decode
    wire         instr_tick = (phase_r == ph_q4);
    wire         sample_pt  = (phase_r == ph_q2) || (phase_r == ph_q4);

    // external source after edge select: falling edge becomes a rising one
    wire         src_lvl    = ext_lvl_r ^ edge_sel;                            // R5
    wire         src_rise   = src_lvl && !src_prev_r;

    // prescaler hookup: owned by exactly one of timer and watchdog
    wire         psc_level;
    wire         psc_wrap;
    wire [7:0]   psc_cnt;
    wire         tmr_step   = !sleep_mode && (src_sel ? src_rise : instr_tick);
    wire         psc_step   = to_wdt ? wdt_base_tick : tmr_step;               // R6
    wire         psc_clear  = to_wdt ? watchdog_clear_instr : wr_cnt;          // R8 R9

    // counter path: prescaler output, or raw pin when bypassed, sampled at q2/q4
    wire         cm_lvl     = to_wdt ? src_lvl : psc_level;                    // R13
    wire         cm_edge    = sample_pt && cm_lvl && !smp_r;                   // R13

    // timer path: every instruction cycle, or each prescaler wrap
    wire         tm_evt     = to_wdt ? instr_tick : psc_wrap;                  // R2
    wire         inc_cand   = !sleep_mode && (src_sel ? cm_edge : tm_evt);     // R4 R12
    wire         inc        = inc_cand && (inhibit_r == 2'h0) && !wr_cnt;      // R3
    wire         ovf        = inc && (timer_count_reg_r == COUNT_MAX);         // R1

    // read data selection; unmapped offsets read zero
    wire [7:0]   intc_rd    = 8'((overflow_flag_r << INTC_FLAG_BIT)
                                | (overflow_irq_enable_r << INTC_IE_BIT));
    wire [7:0]   rd_byte    =
        (wb_adr_i == ADR_COUNT)      ? timer_count_reg_r :
        (wb_adr_i == ADR_OPTION)     ? timer_option_control_r :
        (wb_adr_i == ADR_INTCTL)     ? intc_rd :
        (wb_adr_i == ADR_EVT_STATUS) ? {7'h00, evt_status_r} :
        (wb_adr_i == ADR_EVT_MASK)   ? {7'h00, evt_mask_r} : 8'h00;

    prescale_divider u_psc (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .step    (psc_step),
        .clear   (psc_clear),
        .ratio   (ratio),
        .level   (psc_level),
        .wrap    (psc_wrap),
        .cnt     (psc_cnt)
    );

    // four internal phases make one instruction cycle
    always_comb begin
        case (phase_r)
            ph_q1:   phase_nxt = ph_q2;
            ph_q2:   phase_nxt = ph_q3;
            ph_q3:   phase_nxt = ph_q4;
            default: phase_nxt = ph_q1;
        endcase
    end

    // next values of count, inhibit, flags
    assign timer_count_reg_nxt = wr_cnt ? wb_dat_i[7:0] :
                                 (inc ? timer_count_reg_r + 8'h01 : timer_count_reg_r); // R1
    assign inhibit_nxt = wr_cnt ? INHIBIT_INSTR :
                         ((instr_tick && inhibit_r != 2'h0) ? inhibit_r - 2'h1 : inhibit_r); // R3
    assign overflow_flag_nxt = ovf || (wr_intc ? wb_dat_i[INTC_FLAG_BIT] : overflow_flag_r); // R1
    assign evt_status_nxt = ovf || (!rd_status && evt_status_r);

    // phase sequencer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_r <= ph_q1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // pin synchroniser; level accepted once second and third stages agree
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ext_s1_r  <= 1'b0;
            ext_s2_r  <= 1'b0;
            ext_s3_r  <= 1'b0;
            ext_lvl_r <= 1'b0;
        end else begin
            ext_s1_r  <= external_count_input;
            ext_s2_r  <= ext_s1_r;
            ext_s3_r  <= ext_s2_r;
            ext_lvl_r <= (ext_s2_r == ext_s3_r) ? ext_s3_r : ext_lvl_r;
        end
    end

    // edge history of the source and of the q2/q4 sampler
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            src_prev_r <= 1'b0;
            smp_r      <= 1'b0;
        end else begin
            src_prev_r <= src_lvl;
            smp_r      <= sample_pt ? cm_lvl : smp_r;                            // R13
        end
    end

    // count register and write inhibit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_count_reg_r <= COUNT_RESET;
            inhibit_r         <= 2'h0;
        end else begin
            timer_count_reg_r <= timer_count_reg_nxt;
            inhibit_r         <= inhibit_nxt;
        end
    end

    // option control: low four bits reset to one
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_option_control_r <= OPTION_RESET;                              // R17
        end else if (wr_opt) begin
            timer_option_control_r <= wb_dat_i[7:0];                             // R7
        end
    end

    // overflow flag, enable, event status and mask; a set beats a clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            overflow_flag_r       <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
            evt_status_r          <= 1'b0;
            evt_mask_r            <= 1'b0;
        end else begin
            overflow_flag_r       <= overflow_flag_nxt;                          // R10
            overflow_irq_enable_r <= wr_intc ? wb_dat_i[INTC_IE_BIT] : overflow_irq_enable_r;
            evt_status_r          <= evt_status_nxt;
            evt_mask_r            <= wr_mask ? wb_dat_i[0] : evt_mask_r;
        end
    end

    // interrupt level and watchdog tick outputs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_r      <= 1'b0;
            wdt_tick_r <= 1'b0;
        end else begin
            irq_r      <= (overflow_flag_r && overflow_irq_enable_r)
                          || (evt_status_r && evt_mask_r);                       // R10
            wdt_tick_r <= to_wdt ? psc_wrap : wdt_base_tick;                     // R15
        end
    end

    // bus answer: ack one cycle after the request is taken
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= take;
            dat_r <= (take && !wb_we_i) ? {24'h00_0000, rd_byte} : dat_r;
        end
    end

    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = dat_r;
    assign irq             = irq_r;
    assign wdt_scaled_tick = wdt_tick_r;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_count_write;
        wr_cnt;
    endsequence

    // shortest hold: write lands just before a q4 tick, two ticks pass in five clocks
    sequence s_quiet_window;
        (!inc) [*5];
    endsequence

    property p_wrap_sets_flag;
        ovf |=> overflow_flag_r && (timer_count_reg_r == 8'h00 || $past(wr_cnt));
    endproperty
    a_wrap_sets_flag: assert property (p_wrap_sets_flag)                         // R1
        else $error("overflow did not set flag");

    property p_timer_per_instr;
        (!src_sel && to_wdt && !sleep_mode && inhibit_r == 2'h0 && instr_tick && !wr_cnt)
            |=> timer_count_reg_r == $past(timer_count_reg_r) + 8'h01;
    endproperty
    a_timer_per_instr: assert property (p_timer_per_instr)                       // R2
        else $error("timer mode missed an instruction cycle");

    property p_write_inhibit;
        s_count_write |=> s_quiet_window;
    endproperty
    a_write_inhibit: assert property (p_write_inhibit)                           // R3
        else $error("count advanced inside write inhibit");

    property p_inhibit_blocks;
        (inhibit_r != 2'h0) |-> !inc;
    endproperty
    a_inhibit_blocks: assert property (p_inhibit_blocks)                         // R3
        else $error("count advanced while inhibit pending");

    property p_counter_only_edges;
        (src_sel && inc) |-> sample_pt && !sleep_mode;
    endproperty
    a_counter_only_edges: assert property (p_counter_only_edges)                 // R4 R13
        else $error("counter mode advanced off a sample point");

    property p_write_clears_psc;
        (wr_cnt && !to_wdt) |=> psc_cnt == 8'h00;
    endproperty
    a_write_clears_psc: assert property (p_write_clears_psc)                     // R8
        else $error("count write left prescaler running");

    property p_wdt_clear_psc;
        (watchdog_clear_instr && to_wdt) |=> psc_cnt == 8'h00;
    endproperty
    a_wdt_clear_psc: assert property (p_wdt_clear_psc)                           // R9
        else $error("watchdog clear left prescaler running");

    property p_sleep_hold;
        (sleep_mode && !wr_cnt) |=> $stable(timer_count_reg_r) && !$past(ovf);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)                                 // R12
        else $error("timer moved during sleep");

    property p_irq_enable;
        (overflow_flag_r && overflow_irq_enable_r) |=> irq;
    endproperty
    a_irq_enable: assert property (p_irq_enable)                                 // R10
        else $error("enabled flag did not raise interrupt");

    property p_psc_exclusive;
        (to_wdt && psc_step) |-> wdt_base_tick;
    endproperty
    a_psc_exclusive: assert property (p_psc_exclusive)                           // R6
        else $error("timer stepped a watchdog-owned prescaler");

    property p_ack_one_cycle;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("bus ack not a single cycle");

endmodule

// File: logic/timer_pkg.sv
package timer_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] ADR_COUNT      = 8'h00;
    localparam logic [7:0] ADR_OPTION     = 8'h04;
    localparam logic [7:0] ADR_INTCTL     = 8'h08;
    localparam logic [7:0] ADR_EVT_STATUS = 8'h0c;
    localparam logic [7:0] ADR_EVT_MASK   = 8'h10;

    // option control fields
    localparam int OPT_SRC_SEL_BIT = 5;
    localparam int OPT_EDGE_BIT    = 4;
    localparam int OPT_ASSIGN_BIT  = 3;
    localparam int OPT_RATIO_LSB   = 0;
    localparam int OPT_RATIO_W     = 3;

    // interrupt control fields
    localparam int INTC_FLAG_BIT = 2;
    localparam int INTC_IE_BIT   = 5;

    // reset values and the count maximum
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h0f;
    localparam logic [7:0] COUNT_MAX    = 8'hff;

    // timing: clock period and the count-write inhibit in instruction cycles
    localparam int         CLK_PERIOD_NS     = 10;
    localparam logic [1:0] INHIBIT_INSTR     = 2'h2;
    localparam int         PHASES_PER_INSTR  = 4;
    localparam int         INSTR_PERIOD_NS   = CLK_PERIOD_NS * PHASES_PER_INSTR;

    // internal phase clocks of one instruction cycle
    typedef enum logic [1:0] {ph_q1, ph_q2, ph_q3, ph_q4} phase_t;

endpackage

// File: logic/prescale_divider.sv
`timescale 1ns/10ps
// shared 8-bit divider; software can neither read nor write its count
module prescale_divider
    import timer_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire logic                   step,
    input  wire logic                   clear,
    input  wire logic [OPT_RATIO_W-1:0] ratio,
    output logic                        level,
    output logic                        wrap,
    output logic [7:0]                  cnt
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] low_mask;

    // ratio code n divides by 2^(n+1): wrap when bits n..0 are all ones
    assign low_mask = 8'((9'h2 << ratio) - 9'h1);                       // R16
    assign wrap     = step && !clear && ((cnt_r & low_mask) == low_mask);
    assign level    = cnt_r[ratio];
    assign cnt      = cnt_r;
    assign cnt_nxt  = clear ? 8'h00 : (step ? cnt_r + 8'h01 : cnt_r);  // R8 R9

    // divider count
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// File: dv/ext_clk_src.sv
`timescale 1ns/10ps
// far-side clock source driving the external count pin
module ext_clk_src (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       go,
    input  wire logic       idle_lvl,
    input  wire logic [3:0] n_pulses,
    output logic            pin,
    output logic            busy
);
    logic [3:0] left_r;
    logic [2:0] ph_r;

    // pulse sequencer: four clocks away from idle, four clocks back
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            left_r <= 4'h0;
            ph_r   <= 3'h0;
        end else if (go) begin
            left_r <= n_pulses;
            ph_r   <= 3'h0;
        end else if (left_r != 4'h0) begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == 3'h7) begin
                left_r <= left_r - 4'h1;
            end
        end
    end

    // each level held four clocks so no edge is lost
    assign pin  = idle_lvl ^ ((left_r != 4'h0) && !ph_r[2]);
    assign busy = (left_r != 4'h0);
endmodule

// File: dv/eight_bit_timer_counter_tb.sv
`timescale 1ns/10ps
module eight_bit_timer_counter_tb;
    import timer_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pin;
    logic        sleep_mode = 1'b0;
    logic        wd_clr = 1'b0;
    logic        base_tick = 1'b0;
    logic        scaled_tick;
    logic        irq;
    logic        go = 1'b0;
    logic        idle_lvl = 1'b0;
    logic        busy;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    int          scaled_seen = 0;

    eight_bit_timer_counter eight_bit_timer_counter_inst (
        .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .external_count_input(pin), .sleep_mode(sleep_mode),
        .watchdog_clear_instr(wd_clr), .wdt_base_tick(base_tick),
        .wdt_scaled_tick(scaled_tick), .irq(irq));

    ext_clk_src ext_clk_src_inst (
        .clk_sys(clk_sys), .nrst(nrst), .go(go), .idle_lvl(idle_lvl),
        .n_pulses(4'h3), .pin(pin), .busy(busy));

    // clock, scaled tick tally and hang guard
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (scaled_tick === 1'b1) scaled_seen++;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checked++;
        if ((got inside {[lo:hi]}) !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one classic cycle, then one idle cycle; returns just after an edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, wd};
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1) @(posedge clk_sys);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] t;
        bus(1'b1, adr, d, t);
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] v;
        bus(1'b0, adr, 8'h00, v);
        chk(v, {24'h0, exp});
    endtask

    // count advance between two reads taken gap clocks apart
    task automatic rate(input int gap, input logic [7:0] exp);
        logic [31:0] a;
        logic [31:0] b;
        bus(1'b0, ADR_COUNT, 8'h00, a);
        idle(gap - 3);
        bus(1'b0, ADR_COUNT, 8'h00, b);
        chk({24'h0, b[7:0] - a[7:0]}, {24'h0, exp});
    endtask

    task automatic pulse(input logic clr);
        if (clr) wd_clr <= 1'b1;
        else base_tick <= 1'b1;
        @(posedge clk_sys);
        wd_clr    <= 1'b0;
        base_tick <= 1'b0;
        idle(3);
    endtask

    task automatic t_reset();
        rdchk(ADR_COUNT, COUNT_RESET);
        rdchk(ADR_OPTION, 8'h0f);
        rdchk(ADR_INTCTL, 8'h00);
        rdchk(ADR_EVT_STATUS, 8'h00);
        wr(8'h14, 8'hff);
        rdchk(8'h14, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_timer();
        logic [31:0] v;
        wr(ADR_OPTION, 8'h08);
        rate(40, 8'd10);
        wr(ADR_COUNT, 8'h00);
        idle(37);
        bus(1'b0, ADR_COUNT, 8'h00, v);
        chk_rng(v[7:0], 8'd7, 8'd8);
        sleep_mode <= 1'b1;
        rate(40, 8'd0);
        sleep_mode <= 1'b0;
        $display("test timer done");
    endtask

    task automatic t_prescale();
        for (int n = 0; n < 8; n++) begin
            wr(ADR_OPTION, 8'(n));
            rate(8 << (n + 1), 8'd2);
        end
        wr(ADR_OPTION, 8'h07);
        repeat (8) begin
            wr(ADR_COUNT, 8'h00);
            idle(190);
            rdchk(ADR_COUNT, 8'h00);
        end
        $display("test prescale done");
    endtask

    task automatic t_wdt();
        int s0;
        wr(ADR_OPTION, 8'h08);
        pulse(1'b1);
        s0 = scaled_seen;
        pulse(1'b0);
        pulse(1'b0);
        chk(32'(scaled_seen - s0), 32'h1);
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b0);
        chk(32'(scaled_seen - s0), 32'h1);
        wr(ADR_OPTION, 8'h00);
        pulse(1'b0);
        chk(32'(scaled_seen - s0), 32'h2);
        $display("test watchdog done");
    endtask

    task automatic t_counter();
        // third pass routes the pin through the prescaler at 1:2
        for (int e = 0; e < 3; e++) begin
            idle_lvl <= e[0];
            wr(ADR_OPTION, (e == 2) ? 8'h20 : (e[0] ? 8'h38 : 8'h28));
            wr(ADR_COUNT, 8'h00);
            idle(20);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            @(posedge clk_sys);
            while (busy === 1'b1) @(posedge clk_sys);
            idle(10);
            idle_lvl <= !e[0];
            idle(10);
            rdchk(ADR_COUNT, (e == 2) ? 8'h02 : 8'h04);
        end
        $display("test counter done");
    endtask

    task automatic t_irq();
        logic [31:0] v;
        wr(ADR_OPTION, 8'h08);
        wr(ADR_INTCTL, 8'h00);
        bus(1'b0, ADR_EVT_STATUS, 8'h00, v);
        wr(ADR_COUNT, 8'hfd);
        idle(40);
        rdchk(ADR_INTCTL, 8'h04);
        chk({31'h0, irq}, 32'h0);
        wr(ADR_INTCTL, 8'h24);
        chk({31'h0, irq}, 32'h1);
        wr(ADR_INTCTL, 8'h20);
        chk({31'h0, irq}, 32'h0);
        rdchk(ADR_EVT_STATUS, 8'h01);
        rdchk(ADR_EVT_STATUS, 8'h00);
        wr(ADR_EVT_MASK, 8'h01);
        wr(ADR_INTCTL, 8'h00);
        wr(ADR_COUNT, 8'hfd);
        idle(40);
        chk({31'h0, irq}, 32'h1);
        rdchk(ADR_EVT_STATUS, 8'h01);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
    endtask

    // reset for five clocks, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_timer();
        t_prescale();
        t_wdt();
        t_counter();
        t_irq();
        end_of_test();
    end
endmodule
